// ==== rtl/hub_boot_defines.svh ====
// Constants of the hub boot sequencer: addresses, field positions, timing.
// Assumes a 5 ns core clock; included by bare name from rtl/.
`ifndef HUB_BOOT_DEFINES_SVH
`define HUB_BOOT_DEFINES_SVH

// External ROM probe
`define SIG_ADDR        24'h00_fffa
`define SIG_VALUE       32'h3244_4655
`define EXEC_ADDR       16'h0000
`define RD_CMD          8'h03
`define DUAL_RD_CMD     8'h3b
`define CMD_ADDR_BITS   7'h20
`define SINGLE_TOTAL    7'h40
`define DUAL_DATA_START 7'h28
`define DUAL_TOTAL      7'h38

// Sideband register map
`define END_CFG_ADDR    8'hff
`define CFG_BASE        8'h00
`define OTP_BASE        8'h40
`define GPIO_DIR_ADDR   8'h80
`define GPIO_VAL_ADDR   8'h81
`define GPIO_PULL_ADDR  8'h82
`define GPIO_UP_ADDR    8'h83

// Configuration byte layout
`define OPT_CFG_IDX     0
`define BC_CFG_IDX      1
`define BC_CFG_BIT      0

// Timing
`define CLK_NS          5
`define SPI_HALF_NS     20
`define SPI_HALF_CYC    ((`SPI_HALF_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== rtl/hub_boot_pkg.sv ====
// Types shared by the hub boot sequencer files.
// Assumes nothing beyond the defines header.
package hub_boot_pkg;

  // Gray steps along the boot path
  typedef enum logic [3:0] {
    ST_STANDBY   = 4'h0,
    ST_PROBE     = 4'h1,
    ST_LOAD      = 4'h3,
    ST_STRAP     = 4'h2,
    ST_HOST_CFG  = 4'h6,
    ST_MERGE     = 4'h7,
    ST_IDLE      = 4'h5,
    ST_SUSPEND   = 4'h4,
    ST_CHG_DET   = 4'hc,
    ST_ATTACH    = 4'hd,
    ST_NORMAL    = 4'hf
  } stage_t;

  typedef enum logic [1:0] {
    PH_WAIT  = 2'h0,
    PH_SHIFT = 2'h1,
    PH_DONE  = 2'h3
  } probe_phase_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } byte_wr_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } spi_drive_t;

endpackage

// ==== rtl/hub_boot_sync.sv ====
// Two-stage synchroniser bank for pins and foreign-domain levels.
// Assumes levels that stay stable for several core clocks.
module hub_boot_sync
  import hub_boot_pkg::*;
#(
  parameter int WIDTH = 8
)(
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_clk_en,
  // Data
  input  wire logic [WIDTH-1:0] i_d,
  output      logic [WIDTH-1:0] o_q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.meta = i_d;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_r <= '0;
    else if (i_clk_en)
      st_r <= st_nxt;
  end

  assign o_q = st_r.sync;

endmodule // hub_boot_sync

// ==== rtl/hub_boot_config_sequencer.sv ====
// Boot and mode sequencer of a USB hub: ROM probe, default load, strap
// sampling, host configuration, merge, charger detect, attach, normal.
// Assumes an SMBus slave that hands decoded byte writes on the core clock.
`include "hub_boot_defines.svh"

module hub_boot_config_sequencer
  import hub_boot_pkg::*;
#(
  parameter int                    CFG_DEPTH    = 16,
  parameter int                    N_GPIO       = 8,
  parameter int                    OPT_W        = 8,
  parameter logic [CFG_DEPTH*8-1:0] ROM_DEFAULTS = '0
)(
  // Clock, reset, enable
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rstn,
  input  wire logic                    i_clk_en,
  // Pins and straps
  input  wire logic                    i_pll_lock,
  input  wire logic                    i_spi_opt,
  input  wire logic                    i_spi_mode3,
  input  wire logic                    i_spi_dual,
  input  wire logic                    i_host_config_option,
  input  wire logic                    i_sideband_data_pin,
  input  wire logic                    i_sideband_clock_pin,
  input  wire logic                    i_bc_strap,
  input  wire logic [OPT_W-1:0]        i_pin_opts,
  input  wire logic                    i_vbus,
  // SPI flash pins
  input  wire logic                    i_spi_io0,
  input  wire logic                    i_spi_io1,
  output      logic                    o_spi_sck,
  output      logic                    o_spi_cs_n,
  output      logic                    o_spi_io0,
  output      logic                    o_spi_io0_oe,
  output      logic                    o_spi_oe,
  // Sideband (SMBus) decoded writes
  input  wire byte_wr_t                i_sb_wr,
  // USB-side requests
  input  wire byte_wr_t                i_usb_otp_wr,
  input  wire spi_drive_t              i_usb_spi,
  output      logic                    o_usb_spi_miso,
  input  wire logic                    i_usb_bc_wr,
  input  wire logic                    i_usb_bc_val,
  input  wire logic                    i_usb_enum,
  input  wire logic                    i_mode_change,
  input  wire logic                    i_chg_det_done,
  // GPIO pads
  input  wire logic [N_GPIO-1:0]       i_gpio,
  output      logic [N_GPIO-1:0]       o_gpio,
  output      logic [N_GPIO-1:0]       o_gpio_oe,
  output      logic [N_GPIO-1:0]       o_gpio_pu_en,
  output      logic [N_GPIO-1:0]       o_gpio_pd_en,
  output      logic [N_GPIO-1:0]       o_gpio_level,
  // Status and control out
  output      stage_t                  o_stage,
  output      logic                    o_hub_mode,
  output      logic                    o_pll_en,
  output      logic                    o_ext_rom_en,
  output      logic [15:0]             o_exec_addr,
  output      logic                    o_cfg_valid,
  output      logic [CFG_DEPTH*8-1:0]  o_cfg_applied,
  output      logic                    o_bc_en,
  output      logic                    o_chg_det_en,
  output      logic                    o_suspend,
  output      logic                    o_usb_connect,
  output      logic                    o_hub_active
);

  localparam int IDX_W  = $clog2(CFG_DEPTH);
  localparam int SYNC_W = 10 + OPT_W + N_GPIO;
  localparam logic [2:0] HALF_LAST = 3'(`SPI_HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers

  logic [1:0] rst_pipe_r;
  logic       rst_n;

  // Reset asserts at once, releases on two edges
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rst_pipe_r <= 2'h0;
    else
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end

  assign rst_n = rst_pipe_r[1];

  logic [SYNC_W-1:0] sync_q;
  logic              pll_lock_s;
  logic              spi_opt_s;
  logic              mode3_s;
  logic              dual_s;
  logic              host_opt_s;
  logic              sb_data_s;
  logic              sb_clk_s;
  logic              bc_strap_s;
  logic              vbus_s;
  logic              io0_s;
  logic              io1_s;
  logic [OPT_W-1:0]  opts_s;
  logic [N_GPIO-1:0] gpio_s;

  hub_boot_sync #(
    .WIDTH (SYNC_W + 1)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rstn     (rst_n),
    .i_clk_en   (i_clk_en),
    .i_d        ({i_pll_lock, i_spi_opt, i_spi_mode3, i_spi_dual,
                  i_host_config_option, i_sideband_data_pin, i_sideband_clock_pin,
                  i_bc_strap, i_vbus, i_spi_io0, i_spi_io1, i_pin_opts, i_gpio}),
    .o_q        ({pll_lock_s, sync_q})
  );

  assign {spi_opt_s, mode3_s, dual_s, host_opt_s, sb_data_s, sb_clk_s,
          bc_strap_s, vbus_s, io0_s, io1_s, opts_s, gpio_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    stage_t                        stage;
    probe_phase_t                  ph;
    logic [2:0]                    div;
    logic [6:0]                    bits;
    logic                          smp_any;
    logic                          dual;
    logic [31:0]                   tx;
    logic [31:0]                   rx;
    spi_drive_t                    spi;
    logic                          spi_oe;
    logic                          io0_oe;
    logic                          usb_miso;
    logic [CFG_DEPTH-1:0][7:0]     cfg;
    logic [CFG_DEPTH-1:0][7:0]     otp;
    logic [CFG_DEPTH-1:0]          host_wr;
    logic [CFG_DEPTH-1:0]          otp_prog;
    logic [CFG_DEPTH*8-1:0]        applied;
    logic [N_GPIO-1:0]             g_dir;
    logic [N_GPIO-1:0]             g_val;
    logic [N_GPIO-1:0]             g_pull;
    logic [N_GPIO-1:0]             g_up;
    logic [N_GPIO-1:0]             g_pu_en;
    logic [N_GPIO-1:0]             g_pd_en;
    logic [N_GPIO-1:0]             g_level;
    logic [15:0]                   exec_addr;
    logic                          hub_mode;
    logic                          pll_en;
    logic                          ext_rom;
    logic                          cfg_valid;
    logic                          bc_en;
    logic                          chg_det_en;
    logic                          suspend;
    logic                          connect;
    logic                          hub_active;
  } seq_state_t;

  seq_state_t st_r;
  seq_state_t st_nxt;

  // Address falls inside a CFG_DEPTH-byte window at base
  function automatic logic in_win(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] off;
    off = a - base;
    return (a >= base) && (int'(off) < CFG_DEPTH);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [IDX_W-1:0] sb_idx;
    logic [IDX_W-1:0] usb_idx;
    sb_idx  = i_sb_wr.addr[IDX_W-1:0];
    usb_idx = i_usb_otp_wr.addr[IDX_W-1:0];
    st_nxt          = st_r;
    st_nxt.hub_mode = 1'b1;

    case (st_r.stage)
      ST_STANDBY:
      begin
        st_nxt.stage  = ST_PROBE;
        st_nxt.pll_en = 1'b1;
      end
      ST_PROBE:
      begin
        case (st_r.ph)
          PH_WAIT:
          begin
            // Nothing moves until the PLL reports lock
            if (pll_lock_s && !spi_opt_s)
              st_nxt.stage = ST_LOAD;
            else if (pll_lock_s)
            begin
              st_nxt.ph       = PH_SHIFT;
              st_nxt.dual     = dual_s;
              st_nxt.tx       = {dual_s ? `DUAL_RD_CMD : `RD_CMD, `SIG_ADDR};
              st_nxt.spi.mosi = st_nxt.tx[31];
              st_nxt.spi.sck  = mode3_s;
              st_nxt.spi.cs_n = 1'b0;
              st_nxt.spi_oe   = 1'b1;
              st_nxt.io0_oe   = 1'b1;
              st_nxt.bits     = 7'h0;
              st_nxt.smp_any  = 1'b0;
              st_nxt.div      = 3'h0;
            end
          end
          PH_SHIFT:
          begin
            if (st_r.div == HALF_LAST)
            begin
              st_nxt.div     = 3'h0;
              st_nxt.spi.sck = ~st_r.spi.sck;
              if (!st_r.spi.sck)
              begin
                // Rising edge: sample the flash
                st_nxt.smp_any = 1'b1;
                st_nxt.bits    = st_r.bits + 7'h1;
                if (st_r.dual && st_r.bits >= `DUAL_DATA_START)
                  st_nxt.rx = {st_r.rx[29:0], io1_s, io0_s};
                else if (!st_r.dual && st_r.bits >= `CMD_ADDR_BITS)
                  st_nxt.rx = {st_r.rx[30:0], io1_s};
                if (st_nxt.bits == (st_r.dual ? `DUAL_TOTAL : `SINGLE_TOTAL))
                  st_nxt.ph = PH_DONE;
              end
              else if (st_r.smp_any)
              begin
                // Falling edge: launch next bit; mode 3 skips the leading fall
                st_nxt.tx       = {st_r.tx[30:0], 1'b0};
                st_nxt.spi.mosi = st_r.tx[30];
                if (st_r.dual && st_r.bits == `CMD_ADDR_BITS)
                  st_nxt.io0_oe = 1'b0;
              end
            end
            else
              st_nxt.div = st_r.div + 3'h1;
          end
          PH_DONE:
          begin
            st_nxt.spi.cs_n = 1'b1;
            st_nxt.spi.sck  = mode3_s;
            // Pins released; the board must pull chip select high
            st_nxt.spi_oe   = 1'b0;
            st_nxt.io0_oe   = 1'b0;
            st_nxt.ext_rom  = (st_r.rx == `SIG_VALUE);
            st_nxt.exec_addr = `EXEC_ADDR;
            st_nxt.ph       = PH_WAIT;
            st_nxt.stage    = ST_LOAD;
          end
          default: st_nxt.ph = PH_WAIT;
        endcase
      end
      ST_LOAD:
      begin
        st_nxt.cfg                                = ROM_DEFAULTS;
        st_nxt.cfg[`OPT_CFG_IDX]                  = 8'(opts_s);
        st_nxt.cfg[`BC_CFG_IDX][`BC_CFG_BIT]      = bc_strap_s;
        st_nxt.host_wr                            = '0;
        st_nxt.stage                              = ST_STRAP;
      end
      ST_STRAP:
        // A level high through the synchroniser stands for a pull-up
        st_nxt.stage = (host_opt_s && sb_data_s && sb_clk_s) ?
                       ST_HOST_CFG : ST_MERGE;
      ST_HOST_CFG:
      begin
        if (i_sb_wr.valid && i_sb_wr.addr == `END_CFG_ADDR)
          st_nxt.stage = ST_MERGE;
        else if (i_sb_wr.valid && in_win(i_sb_wr.addr, `CFG_BASE))
        begin
          st_nxt.cfg[sb_idx]     = i_sb_wr.data;
          st_nxt.host_wr[sb_idx] = 1'b1;
        end
        else if (i_sb_wr.valid && in_win(i_sb_wr.addr, `OTP_BASE))
        begin
          st_nxt.otp[sb_idx]      = st_r.otp[sb_idx] | i_sb_wr.data;
          st_nxt.otp_prog[sb_idx] = 1'b1;
        end
      end
      ST_MERGE:
      begin
        // Host writes beat OTP, OTP beats defaults
        for (int i = 0; i < CFG_DEPTH; i++)
        begin
          if (st_r.otp_prog[i] && !st_r.host_wr[i])
            st_nxt.cfg[i] = st_r.otp[i];
        end
        st_nxt.applied   = st_nxt.cfg;
        st_nxt.cfg_valid = 1'b1;
        st_nxt.bc_en     = st_nxt.cfg[`BC_CFG_IDX][`BC_CFG_BIT];
        st_nxt.stage     = ST_IDLE;
      end
      ST_IDLE, ST_SUSPEND:
      begin
        st_nxt.suspend = !vbus_s;
        if (vbus_s)
        begin
          st_nxt.stage      = st_r.bc_en ? ST_CHG_DET : ST_ATTACH;
          st_nxt.chg_det_en = st_r.bc_en;
        end
        else
          st_nxt.stage = ST_SUSPEND;
      end
      ST_CHG_DET:
      begin
        if (!vbus_s)
        begin
          st_nxt.stage      = ST_IDLE;
          st_nxt.chg_det_en = 1'b0;
        end
        else if (i_chg_det_done)
        begin
          st_nxt.stage      = ST_ATTACH;
          st_nxt.chg_det_en = 1'b0;
        end
      end
      ST_ATTACH:
      begin
        st_nxt.connect = vbus_s;
        if (!vbus_s)
          st_nxt.stage = ST_IDLE;
        else if (i_usb_enum)
        begin
          st_nxt.stage      = ST_NORMAL;
          st_nxt.hub_active = 1'b1;
        end
      end
      ST_NORMAL:
      begin
        st_nxt.spi      = i_usb_spi;
        st_nxt.spi_oe   = 1'b1;
        st_nxt.io0_oe   = 1'b1;
        st_nxt.usb_miso = io1_s;
        if (i_usb_otp_wr.valid && in_win(i_usb_otp_wr.addr, `OTP_BASE))
        begin
          st_nxt.otp[usb_idx]      = st_r.otp[usb_idx] | i_usb_otp_wr.data;
          st_nxt.otp_prog[usb_idx] = 1'b1;
        end
        if (i_usb_bc_wr)
          st_nxt.bc_en = i_usb_bc_val;
        if (i_mode_change)
        begin
          st_nxt.stage      = ST_IDLE;
          st_nxt.hub_active = 1'b0;
          st_nxt.connect    = 1'b0;
          st_nxt.spi_oe     = 1'b0;
          st_nxt.io0_oe     = 1'b0;
        end
      end
      default: st_nxt.stage = ST_STANDBY;
    endcase

    // GPIO registers are open once the hub has left standby
    if (i_sb_wr.valid && st_r.stage != ST_STANDBY)
    begin
      case (i_sb_wr.addr)
        `GPIO_DIR_ADDR:  st_nxt.g_dir  = N_GPIO'(i_sb_wr.data);
        `GPIO_VAL_ADDR:  st_nxt.g_val  = N_GPIO'(i_sb_wr.data);
        `GPIO_PULL_ADDR: st_nxt.g_pull = N_GPIO'(i_sb_wr.data);
        `GPIO_UP_ADDR:   st_nxt.g_up   = N_GPIO'(i_sb_wr.data);
        default:         st_nxt.g_dir  = st_nxt.g_dir;
      endcase
    end
    // Pulls only ever apply to inputs
    st_nxt.g_pu_en = ~st_nxt.g_dir & st_nxt.g_pull & st_nxt.g_up;
    st_nxt.g_pd_en = ~st_nxt.g_dir & st_nxt.g_pull & ~st_nxt.g_up;
    st_nxt.g_level = gpio_s;
  end

  // All state clears together: nothing survives standby
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else if (i_clk_en)
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign o_spi_sck     = st_r.spi.sck;
  assign o_spi_cs_n    = st_r.spi.cs_n;
  assign o_spi_io0     = st_r.spi.mosi;
  assign o_spi_io0_oe  = st_r.io0_oe;
  assign o_spi_oe      = st_r.spi_oe;
  assign o_usb_spi_miso = st_r.usb_miso;
  assign o_gpio        = st_r.g_val;
  assign o_gpio_oe     = st_r.g_dir;
  assign o_gpio_pu_en  = st_r.g_pu_en;
  assign o_gpio_pd_en  = st_r.g_pd_en;
  assign o_gpio_level  = st_r.g_level;
  assign o_stage       = st_r.stage;
  assign o_hub_mode    = st_r.hub_mode;
  assign o_pll_en      = st_r.pll_en;
  assign o_ext_rom_en  = st_r.ext_rom;
  assign o_exec_addr   = st_r.exec_addr;
  assign o_cfg_valid   = st_r.cfg_valid;
  assign o_cfg_applied = st_r.applied;
  assign o_bc_en       = st_r.bc_en;
  assign o_chg_det_en  = st_r.chg_det_en;
  assign o_suspend     = st_r.suspend;
  assign o_usb_connect = st_r.connect;
  assign o_hub_active  = st_r.hub_active;

endmodule // hub_boot_config_sequencer

// ==== bench/hub_boot_flash.sv ====
// SPI flash model that answers the signature read of the boot probe.
// Assumes 32 clocks of command and address, plus 8 dummy clocks in dual.
module hub_boot_flash
(
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_dual,
  input  wire logic i_bad,
  output logic      o_io0 = 1'b0,
  output logic      o_io1 = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  int          cnt;
  logic [31:0] w;
  assign w = i_bad ? 32'h3244_4654 : 32'h3244_4655;
  always @(posedge i_sck or posedge i_cs_n)
    cnt <= i_cs_n ? 0 : cnt + 1;
  // Data moves on the falling edge so it is stable for a full half period
  always @(negedge i_sck or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      o_io0 <= ~o_io0;
      o_io1 <= ~o_io1;
    end
    else if (i_dual && cnt >= 40 && cnt < 56)
      {o_io1, o_io0} <= w[111-2*cnt -: 2];
    else if (!i_dual && cnt >= 32 && cnt < 64)
      o_io1 <= w[63-cnt];
  end
endmodule // hub_boot_flash

// ==== bench/hub_boot_config_sequencer_chk.sv ====
// Assertions on the ports of the boot sequencer.
// Assumes the core clock domain only; bound from the bench top.
module hub_boot_config_sequencer_chk
  import hub_boot_pkg::*;
#(
  parameter int N_GPIO = 8
)(
  input wire logic              i_core_clk,
  input wire logic              i_rstn,
  input wire logic              i_clk_en,
  input wire byte_wr_t          i_sb_wr,
  input wire logic              i_mode_change,
  input wire stage_t            o_stage,
  input wire logic              o_hub_mode,
  input wire logic              o_pll_en,
  input wire logic              o_spi_oe,
  input wire logic              o_spi_cs_n,
  input wire logic              o_ext_rom_en,
  input wire logic [15:0]       o_exec_addr,
  input wire logic              o_suspend,
  input wire logic              o_usb_connect,
  input wire logic [N_GPIO-1:0] o_gpio_oe,
  input wire logic [N_GPIO-1:0] o_gpio_pu_en,
  input wire logic [N_GPIO-1:0] o_gpio_pd_en
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic endw;
  assign endw = i_clk_en && i_sb_wr.valid && i_sb_wr.addr == 8'hff;
  AST_STANDBY_OFF:
    assert property (o_stage == ST_STANDBY |-> !o_hub_mode && !o_pll_en && !o_spi_oe)
    else $error("standby outputs active");
  AST_HUB_MODE:
    assert property (o_stage != ST_STANDBY |-> o_hub_mode)
    else $error("hub mode low outside standby");
  AST_PROBE_FIRST:
    assert property (o_stage == ST_STANDBY ##1 o_stage != ST_STANDBY |-> o_stage == ST_PROBE)
    else $error("release did not enter probe");
  AST_EXT_ROM:
    assert property ($rose(o_ext_rom_en) |-> o_exec_addr == 16'h0000 && o_stage inside {ST_PROBE, ST_LOAD})
    else $error("external boot set wrongly");
  AST_SPI_FRAME:
    assert property (o_spi_oe && !o_spi_cs_n |-> o_stage inside {ST_PROBE, ST_NORMAL})
    else $error("flash selected outside probe");
  AST_HOST_WAIT:
    assert property (o_stage == ST_HOST_CFG && !endw && !$past(endw) |=> o_stage == ST_HOST_CFG)
    else $error("host stage left early");
  AST_HOST_END:
    assert property (o_stage == ST_HOST_CFG && endw |-> ##[1:2] o_stage == ST_MERGE)
    else $error("end write ignored");
  AST_SUSPEND:
    assert property ((o_stage == ST_SUSPEND)[*2] |-> o_suspend)
    else $error("suspend flag missing");
  AST_CONNECT:
    assert property (o_usb_connect |-> o_stage inside {ST_ATTACH, ST_NORMAL} ||
                     $past(o_stage) inside {ST_ATTACH, ST_NORMAL})
    else $error("connect outside attach");
  AST_NORMAL_STAY:
    assert property (o_stage == ST_NORMAL && !i_mode_change && !$past(i_mode_change)
                     |=> o_stage == ST_NORMAL)
    else $error("normal mode left");
  AST_GPIO_DIR:
    assert property (i_clk_en && i_sb_wr.valid && i_sb_wr.addr == 8'h80 && o_stage != ST_STANDBY
                     |=> o_gpio_oe == $past(i_sb_wr.data[N_GPIO-1:0]))
    else $error("gpio direction not written");
  AST_GPIO_PULL:
    assert property (((o_gpio_oe | o_gpio_pu_en) & o_gpio_pd_en) == '0 && (o_gpio_oe & o_gpio_pu_en) == '0)
    else $error("gpio pull conflict");
  C_HOST: cover property (o_stage == ST_HOST_CFG ##1 o_stage == ST_MERGE);
  C_NORMAL: cover property (o_stage == ST_NORMAL);
  C_EXT: cover property ($rose(o_ext_rom_en));
endmodule // hub_boot_config_sequencer_chk

// ==== bench/tb.sv ====
// Bench top: boot sequencer with flash model, stimulus tasks and checks.
// Assumes a 200 MHz core clock; the clock gate stays open but for one freeze check.
module tb;
  import hub_boot_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk, i_rstn, i_clk_en, i_pll_lock, i_spi_opt, i_spi_mode3, i_spi_dual, bad;
  logic i_host_config_option, i_sideband_data_pin, i_sideband_clock_pin, i_bc_strap, i_vbus;
  logic i_usb_bc_wr, i_usb_bc_val, i_usb_enum, i_mode_change, i_chg_det_done, oe_seen;
  logic o_spi_sck, o_spi_cs_n, o_spi_io0, o_spi_io0_oe, o_spi_oe, o_usb_spi_miso, o_hub_mode;
  logic o_pll_en, o_ext_rom_en, o_cfg_valid, o_bc_en, o_chg_det_en, o_suspend, o_usb_connect;
  logic o_hub_active;
  logic [7:0]   i_pin_opts, i_gpio, o_gpio, o_gpio_oe, o_gpio_pu_en, o_gpio_pd_en, o_gpio_level;
  logic [15:0]  o_exec_addr;
  logic [127:0] o_cfg_applied;
  byte_wr_t     i_sb_wr, i_usb_otp_wr;
  spi_drive_t   i_usb_spi;
  stage_t       o_stage;
  wire          fl_io0, fl_io1, i_spi_io1;
  wire          i_spi_io0 = o_spi_io0_oe ? o_spi_io0 : fl_io0;
  int           n_fail, n_checks;
  assign i_spi_io1 = fl_io1;
  hub_boot_config_sequencer hub_boot_config_sequencer_inst (.i_core_clk, .i_rstn, .i_clk_en,
    .i_pll_lock, .i_spi_opt, .i_spi_mode3, .i_spi_dual, .i_host_config_option,
    .i_sideband_data_pin, .i_sideband_clock_pin, .i_bc_strap, .i_pin_opts, .i_vbus, .i_spi_io0,
    .i_spi_io1, .o_spi_sck, .o_spi_cs_n, .o_spi_io0, .o_spi_io0_oe, .o_spi_oe, .i_sb_wr,
    .i_usb_otp_wr, .i_usb_spi, .o_usb_spi_miso, .i_usb_bc_wr, .i_usb_bc_val, .i_usb_enum,
    .i_mode_change, .i_chg_det_done, .i_gpio, .o_gpio, .o_gpio_oe, .o_gpio_pu_en, .o_gpio_pd_en,
    .o_gpio_level, .o_stage, .o_hub_mode, .o_pll_en, .o_ext_rom_en, .o_exec_addr, .o_cfg_valid,
    .o_cfg_applied, .o_bc_en, .o_chg_det_en, .o_suspend, .o_usb_connect, .o_hub_active);
  // Released pins: chip select pulled up, clock held at its idle level so no false edge
  hub_boot_flash hub_boot_flash_inst (.i_sck(o_spi_oe ? o_spi_sck : i_spi_mode3),
    .i_cs_n(o_spi_cs_n | ~o_spi_oe),
    .i_dual(i_spi_dual), .i_bad(bad), .o_io0(fl_io0), .o_io1(fl_io1));
  always @(posedge i_core_clk)
    if (o_spi_oe === 1'b1)
      oe_seen <= 1'b1;
  initial
  begin
    i_core_clk = 0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(int n = 1);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic wst(stage_t s);
    for (int k = 0; k < 3000 && o_stage !== s; k++)
      cyc();
    chk("stage", o_stage, s);
  endtask
  task automatic sbw(logic [7:0] a, logic [7:0] d);
    i_sb_wr = '{1'b1, a, d};
    cyc();
    i_sb_wr = '0;
    cyc();
  endtask
  // Reset, set straps, run the probe and strap stages
  task automatic boot(logic [6:0] c, logic ext, stage_t nx);
    cyc();
    i_rstn = 0;
    #1;
    chk("standby", {o_stage, o_hub_mode, o_pll_en, o_spi_oe, o_cfg_valid, o_usb_connect, o_gpio_oe},
      {ST_STANDBY, 13'h0000});
    {i_spi_opt, i_spi_mode3, i_spi_dual, bad, i_host_config_option, i_sideband_data_pin,
      i_sideband_clock_pin} = c;
    cyc(2);
    oe_seen = 0;
    i_rstn = 1;
    wst(ST_PROBE);
    chk("pll", o_pll_en, 1);
    wst(ST_STRAP);
    chk("rom", {oe_seen, o_ext_rom_en, o_exec_addr}, {i_spi_opt, ext, 16'h0000});
    wst(nx);
  endtask
  task automatic t_host();
    boot(7'b100_0111, 1, ST_HOST_CFG);
    cyc(40);
    chk("wait", o_stage, ST_HOST_CFG);
    // An end write while the clock gate is shut must be lost
    i_clk_en = 0;
    sbw(8'hff, 8'h00);
    chk("frz", o_stage, ST_HOST_CFG);
    i_clk_en = 1;
    sbw(8'h01, 8'h00);
    sbw(8'h42, 8'h0c);
    sbw(8'h80, 8'h01);
    sbw(8'h81, 8'h01);
    sbw(8'h82, 8'h02);
    sbw(8'h83, 8'h02);
    chk("gpio", {o_gpio[0], o_gpio_oe, o_gpio_pu_en, o_gpio_pd_en}, {1'b1, 24'h01_0200});
    i_gpio = 8'ha5;
    cyc(4);
    chk("lvl", o_gpio_level, 8'ha5);
    i_sb_wr = '{1'b1, 8'hff, 8'h00};
    cyc();
    i_sb_wr = '0;
    wst(ST_MERGE);
    wst(ST_SUSPEND);
    cyc(2);
    chk("cfg", {o_cfg_valid, o_suspend, o_bc_en, o_cfg_applied[23:0]},
      {3'b110, 24'h0c_005a});
    i_vbus = 1;
    wst(ST_ATTACH);
    cyc(4);
    chk("conn", o_usb_connect, 1);
    i_vbus = 0;
    wst(ST_IDLE);
    $display("test host done");
  endtask
  task automatic t_run();
    boot(7'b000_0000, 0, ST_MERGE);
    i_vbus = 1;
    wst(ST_CHG_DET);
    chk("bc", {o_bc_en, o_chg_det_en}, 2'b11);
    i_chg_det_done = 1;
    wst(ST_ATTACH);
    i_chg_det_done = 0;
    i_usb_enum = 1;
    wst(ST_NORMAL);
    i_usb_enum = 0;
    i_vbus = 0;
    i_usb_spi = '{1'b1, 1'b0, 1'b1};
    i_usb_bc_wr = 1;
    cyc();
    i_usb_bc_wr = 0;
    cyc(4);
    chk("norm", {o_stage, o_hub_active, o_bc_en, o_spi_sck, o_spi_cs_n, o_spi_io0, o_spi_oe,
      o_spi_io0_oe}, {ST_NORMAL, 7'b1010111});
    chk("miso", o_usb_spi_miso, i_spi_io1);
    i_mode_change = 1;
    cyc();
    i_mode_change = 0;
    wst(ST_IDLE);
    $display("test run done");
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {i_rstn, i_spi_opt, i_spi_mode3, i_spi_dual, bad, i_host_config_option, i_sideband_data_pin,
      i_sideband_clock_pin, i_vbus, i_usb_bc_wr, i_usb_bc_val, i_usb_enum, i_mode_change,
      i_chg_det_done, oe_seen} = '0;
    {i_clk_en, i_pll_lock, i_bc_strap} = 3'b111;
    {i_sb_wr, i_usb_otp_wr, i_usb_spi, i_gpio} = '0;
    i_pin_opts = 8'h5a;
    t_host();
    t_run();
    boot(7'b100_1100, 0, ST_MERGE);
    boot(7'b111_0011, 1, ST_MERGE);
    $display("test probe done");
    end_sim();
  end
  initial
  begin
    #100000;
    n_fail++;
    end_sim();
  end
endmodule // tb
bind hub_boot_config_sequencer hub_boot_config_sequencer_chk #(.N_GPIO(N_GPIO)) chk_inst (
  .i_core_clk, .i_rstn, .i_clk_en, .i_sb_wr, .i_mode_change, .o_stage, .o_hub_mode, .o_pll_en,
  .o_spi_oe, .o_spi_cs_n, .o_ext_rom_en, .o_exec_addr, .o_suspend, .o_usb_connect, .o_gpio_oe,
  .o_gpio_pu_en, .o_gpio_pd_en);
